// [design/cusc_pkg.sv]
// Shared constants, types and index helpers for the configurable cache.
// Assumes one core clock; the core and the external bus sit on that clock.
package cusc_pkg;

	// ********************************************************
	// Geometry
	// ********************************************************
	localparam int ADDR_W   = 32;
	localparam int DATA_W   = 32;
	localparam int LINES    = 512;              // Tag entries
	localparam int WORDS    = 2048;             // Data array words
	localparam int WPL      = 4;                // Words per 16-byte line
	localparam int IDX_W    = 9;
	localparam int WSEL_W   = 2;
	localparam int DIDX_W   = IDX_W + WSEL_W;
	localparam int WORD_LSB = 2;
	localparam int IDX_LSB  = 4;
	localparam int TAG_LSB  = 12;
	localparam int TAG_W    = ADDR_W - TAG_LSB;

	// ********************************************************
	// Configuration register layout
	// ********************************************************
	localparam int        CFG_W        = 4;
	localparam int        CFG_INV_BIT  = 0;     // Write-one: invalidate all
	localparam int        CFG_MODE_LSB = 1;     // Two-bit organisation
	localparam int        CFG_EN_BIT   = 3;     // Cache enable
	localparam logic [3:0] CFG_RST     = 4'h0;
	localparam logic [1:0] MODE_INSTR  = 2'h0;
	localparam logic [1:0] MODE_DATA   = 2'h1;
	localparam logic [1:0] MODE_SPLIT  = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FILL,
		ST_COMMIT,
		ST_SINGLE,
		ST_WRITE
	} cusc_state_t;

	// Line index; split mode keeps fetches in the low half, data high
	function automatic logic [IDX_W-1:0] cusc_index(
		input logic [ADDR_W-1:0] a,
		input logic [1:0]        m,
		input logic              ifetch);
		if (m == MODE_SPLIT) begin
			cusc_index = {~ifetch, a[IDX_LSB+IDX_W-2:IDX_LSB]};
		end else begin
			cusc_index = a[IDX_LSB+IDX_W-1:IDX_LSB];
		end
	endfunction : cusc_index

	// Which access kinds the organisation caches
	function automatic logic cusc_cacheable(
		input logic [1:0] m,
		input logic       ifetch);
		case (m)
			MODE_INSTR: cusc_cacheable = ifetch;
			MODE_DATA:  cusc_cacheable = ~ifetch;
			MODE_SPLIT: cusc_cacheable = 1'b1;
			default:    cusc_cacheable = 1'b0;
		endcase
	endfunction : cusc_cacheable

endpackage : cusc_pkg

// [design/cusc_fill_buf.sv]
// Line fill buffer: gathers the words of one burst in arrival order.
// Assumes the owner clears it before each new fill.
`timescale 1ns/100ps
`default_nettype none
module cusc_fill_buf #(
	parameter int WORD_W = 32,
	parameter int NWORDS = 4,
	parameter int CNT_W  = $clog2(NWORDS) + 1
) (
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     rst_n,
	// Fill side
	input  wire logic                     clear,
	input  wire logic                     wr_en,
	input  wire logic [WORD_W-1:0]        wdata,
	// Collected line
	output logic      [NWORDS*WORD_W-1:0] line_o,
	output logic      [CNT_W-1:0]         count_o
);

	logic [WORD_W-1:0] words_r [NWORDS];
	logic [CNT_W-1:0]  count_r;

	// Word count; a full buffer drops further writes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= '0;
		end else if (clear) begin
			count_r <= '0;
		end else if (wr_en && count_r < CNT_W'(NWORDS)) begin
			count_r <= count_r + 1'b1;
		end
	end

	// Storage needs no reset: the count says what is valid
	always_ff @(posedge sys_clk) begin
		if (wr_en && !clear && count_r < CNT_W'(NWORDS)) begin
			words_r[count_r[CNT_W-2:0]] <= wdata;
		end
	end

	genvar i;
	generate
		for (i = 0; i < NWORDS; i++) begin : g_line
			assign line_o[i*WORD_W +: WORD_W] = words_r[i];
		end
	endgenerate
	assign count_o = count_r;

	a_fill_count_cap: assert property (@(posedge sys_clk) disable iff (!rst_n)
		count_r <= CNT_W'(NWORDS))
		else $error("Fill buffer count beyond one line");

endmodule : cusc_fill_buf
`default_nettype wire

// [design/cusc_top.sv]
// Direct-mapped 8-Kbyte cache between the core local bus and external bus.
// Assumes core and external bus share sys_clk; the core holds off new
// requests until core_ready_r pulses.
`timescale 1ns/100ps
`default_nettype none
module cusc_top
	import cusc_pkg::*;
(
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// Configuration write port
	input  wire logic              cfg_wr_en,
	input  wire logic              cfg_supervisor,
	input  wire logic [CFG_W-1:0]  cfg_wdata,
	output logic      [CFG_W-1:0]  cache_config_reg,
	// Core local bus
	input  wire logic              core_req,
	input  wire logic              core_ifetch,
	input  wire logic              core_we,
	input  wire logic [ADDR_W-1:0] core_addr,
	input  wire logic [DATA_W-1:0] core_wdata,
	output logic      [DATA_W-1:0] core_rdata_r,
	output logic                   core_ready_r,
	output logic                   core_miss_r,
	// External bus
	output logic                   ext_req_r,
	output logic                   ext_we_r,
	output logic                   ext_burst_r,
	output logic      [ADDR_W-1:0] ext_addr_r,
	output logic      [DATA_W-1:0] ext_wdata_r,
	input  wire logic              ext_ack,
	input  wire logic [DATA_W-1:0] ext_rdata
);

	localparam int FB_CW = $clog2(WPL) + 1;

	// ********************************************************
	// Storage and state
	// ********************************************************
	logic [CFG_W-1:0]  cfg_r;
	logic [LINES-1:0]  valid_r;
	logic [TAG_W-1:0]  tag_r   [LINES];
	logic [DATA_W-1:0] data_r  [WORDS];
	cusc_state_t       state_r;
	logic [IDX_W-1:0]  req_idx_r;
	logic [TAG_W-1:0]  req_tag_r;
	logic [WSEL_W-1:0] req_wsel_r;

	logic [1:0]            mode;
	logic                  take;
	logic [IDX_W-1:0]      cur_idx;
	logic [TAG_W-1:0]      cur_tag;
	logic [DIDX_W-1:0]     cur_didx;
	logic                  cur_cacheable;
	logic                  cur_hit;
	logic                  fill_last;
	logic [WPL*DATA_W-1:0] fb_line;
	logic [FB_CW-1:0]      fb_count;

	// ********************************************************
	// Lookup on the request as presented
	// ********************************************************
	assign mode          = cfg_r[CFG_MODE_LSB +: 2];
	assign take          = core_req && state_r == ST_IDLE;
	assign cur_idx       = cusc_index(core_addr, mode, core_ifetch);
	assign cur_tag       = core_addr[ADDR_W-1:TAG_LSB];
	assign cur_didx      = {cur_idx, core_addr[IDX_LSB-1:WORD_LSB]};
	assign cur_cacheable = cfg_r[CFG_EN_BIT]
		&& cusc_cacheable(mode, core_ifetch);
	// One line per address: compare only the indexed tag
	assign cur_hit = cur_cacheable && valid_r[cur_idx]
		&& tag_r[cur_idx] == cur_tag;
	assign fill_last = ext_ack && fb_count == FB_CW'(WPL - 1);
	assign cache_config_reg = cfg_r;

	// Config: user-mode writes are dropped silently
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= CFG_RST;
		end else if (cfg_wr_en && cfg_supervisor) begin
			cfg_r <= cfg_wdata & ~(CFG_W'(1) << CFG_INV_BIT);
		end
	end

	// Valid bits; a mode change does not flush, software must invalidate
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_r <= '0;
		end else if (cfg_wr_en && cfg_supervisor
			&& cfg_wdata[CFG_INV_BIT]) begin
			valid_r <= '0;
		end else if (state_r == ST_COMMIT) begin
			valid_r[req_idx_r] <= 1'b1;
		end
	end

	// Tag and data arrays; line lands from the fill buffer in one cycle
	always_ff @(posedge sys_clk) begin
		if (state_r == ST_COMMIT) begin
			tag_r[req_idx_r] <= req_tag_r;
			for (int w = 0; w < WPL; w++) begin
				data_r[{req_idx_r, WSEL_W'(w)}]
					<= fb_line[w*DATA_W +: DATA_W];
			end
		end else if (take && core_we && cur_hit) begin
			data_r[cur_didx] <= core_wdata;
		end
	end

	// Request capture for the miss path
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_idx_r  <= '0;
			req_tag_r  <= '0;
			req_wsel_r <= '0;
		end else if (take) begin
			req_idx_r  <= cur_idx;
			req_tag_r  <= cur_tag;
			req_wsel_r <= core_addr[IDX_LSB-1:WORD_LSB];
		end
	end

	// ********************************************************
	// Sequencer
	// ********************************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (take && core_we) begin
						state_r <= ST_WRITE;
					end else if (take && cur_cacheable && !cur_hit) begin
						state_r <= ST_FILL;
					end else if (take && !cur_cacheable) begin
						state_r <= ST_SINGLE;
					end
				end
				ST_FILL: begin
					if (fill_last) begin
						state_r <= ST_COMMIT;
					end
				end
				ST_COMMIT: state_r <= ST_IDLE;
				ST_SINGLE, ST_WRITE: begin
					if (ext_ack) begin
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Core answer: hits read the array straight onto the local bus
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_rdata_r <= '0;
			core_ready_r <= 1'b0;
			core_miss_r  <= 1'b0;
		end else begin
			core_ready_r <= 1'b0;
			core_miss_r  <= take && !core_we
				&& cur_cacheable && !cur_hit;
			if (take && !core_we && cur_hit) begin
				core_rdata_r <= data_r[cur_didx];
				core_ready_r <= 1'b1;
			end else if (state_r == ST_COMMIT) begin
				core_rdata_r <= fb_line[req_wsel_r*DATA_W +: DATA_W];
				core_ready_r <= 1'b1;
			end else if (state_r == ST_SINGLE && ext_ack) begin
				core_rdata_r <= ext_rdata;
				core_ready_r <= 1'b1;
			end else if (state_r == ST_WRITE && ext_ack) begin
				core_ready_r <= 1'b1;
			end
		end
	end

	// External bus: request held until the last acknowledge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_req_r   <= 1'b0;
			ext_we_r    <= 1'b0;
			ext_burst_r <= 1'b0;
			ext_addr_r  <= '0;
			ext_wdata_r <= '0;
		end else if (take && (core_we || !cur_hit)) begin
			ext_req_r   <= 1'b1;
			ext_we_r    <= core_we;
			ext_burst_r <= !core_we && cur_cacheable;
			ext_addr_r  <= (!core_we && cur_cacheable)
				? {core_addr[ADDR_W-1:IDX_LSB], 4'h0} : core_addr;
			ext_wdata_r <= core_wdata;
		end else if ((state_r == ST_FILL && fill_last)
			|| ((state_r == ST_SINGLE || state_r == ST_WRITE) && ext_ack)) begin
			ext_req_r   <= 1'b0;
			ext_we_r    <= 1'b0;
			ext_burst_r <= 1'b0;
		end
	end

	cusc_fill_buf #(
		.WORD_W (DATA_W),
		.NWORDS (WPL)
	) u_fill (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.clear   (state_r == ST_COMMIT || take),
		.wr_en   (state_r == ST_FILL && ext_ack),
		.wdata   (ext_rdata),
		.line_o  (fb_line),
		.count_o (fb_count)
	);

	// ********************************************************
	// Checks
	// ********************************************************
	a_hit_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take && !core_we && cur_hit |=> core_ready_r && !core_miss_r)
		else $error("Read hit not answered next cycle");

	a_miss_burst: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take && !core_we && cur_cacheable && !cur_hit
		|=> core_miss_r && ext_req_r && ext_burst_r
		&& ext_addr_r[3:0] == 4'h0)
		else $error("Miss did not start aligned line fetch");

	a_write_through: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take && core_we |=> ext_req_r && ext_we_r && !ext_burst_r)
		else $error("Write did not reach external bus");

	a_cfg_privilege: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cfg_wr_en && !cfg_supervisor |=> $stable(cfg_r))
		else $error("User write changed configuration");

	a_split_halves: assert property (@(posedge sys_clk) disable iff (!rst_n)
		mode == MODE_SPLIT |-> cur_idx[IDX_W-1] == !core_ifetch)
		else $error("Split mode used wrong half");

	a_no_write_alloc: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take && core_we && !cur_hit |=> state_r == ST_WRITE
		&& $stable(valid_r))
		else $error("Write miss allocated a line");

	a_fill_commit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == ST_FILL && fill_last |=> state_r == ST_COMMIT
		&& fb_count == FB_CW'(WPL) ##1 core_ready_r && valid_r[req_idx_r])
		else $error("Line not committed after fourth word");

	a_line_geometry: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take |-> cur_didx[WSEL_W-1:0] == core_addr[3:2]
		&& cur_didx[DIDX_W-1:WSEL_W] == cur_idx)
		else $error("Word index does not follow line index");

endmodule : cusc_top
`default_nettype wire

// [tb/cusc_ext_mem.sv]
// External memory model that answers the cache's external bus.
// Assumes the shared core clock; lat sets the wait before each word.
`timescale 1ns/100ps
`default_nettype none
module cusc_ext_mem (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// External bus from the cache
	input  wire logic        ext_req_r,
	input  wire logic        ext_we_r,
	input  wire logic        ext_burst_r,
	input  wire logic [31:0] ext_addr_r,
	input  wire logic [31:0] ext_wdata_r,
	output logic             ext_ack,
	output logic      [31:0] ext_rdata,
	// Bench control
	input  wire logic [1:0]  lat
);
	logic [31:0] mem [logic [31:0]];
	int          n_wr = 0;
	int          beat = 0;
	int          wc   = 0;

	// Unwritten words read as a pattern of their own address
	function automatic logic [31:0] rd(input logic [31:0] a);
		return mem.exists(a) ? mem[a] : {a[15:0], ~a[15:0]};
	endfunction : rd

	// One word per ack; idle data toggles so a stale word never matches
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_ack   <= 1'b0;
			ext_rdata <= 32'h0;
		end else begin
			ext_ack   <= 1'b0;
			ext_rdata <= ~ext_rdata;
			if (ext_req_r && ext_ack) begin
				if (ext_we_r) begin
					mem[ext_addr_r] = ext_wdata_r;
					n_wr++;
				end
				beat++;
			end
			if (!ext_req_r) begin
				beat = 0;
			end else if (beat < (ext_burst_r ? 4 : 1)) begin
				if (wc < int'(lat)) begin
					wc++;
				end else begin
					wc = 0;
					ext_ack   <= 1'b1;
					ext_rdata <= rd(ext_addr_r + 32'(beat * 4));
				end
			end
		end
	end
endmodule : cusc_ext_mem
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the cache, random traffic in every organisation.
// Assumes the memory model above stands on the external bus.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
	num_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
	import cusc_pkg::*;
	logic        sys_clk, rst_n, cfg_wr_en, cfg_supervisor;
	logic [3:0]  cfg_wdata, cache_config_reg;
	logic        core_req, core_ifetch, core_we;
	logic [31:0] core_addr, core_wdata, core_rdata_r;
	logic        core_ready_r, core_miss_r, ext_req_r, ext_we_r;
	logic        ext_burst_r, ext_ack;
	logic [31:0] ext_addr_r, ext_wdata_r, ext_rdata;
	logic [1:0]  lat, mode;
	logic        en;
	logic        v [512];
	logic [19:0] tg [512];
	logic [31:0] cd [2048];
	int          num_errors = 0;
	int          comparisons = 0;
	int          cyc_cnt = 0;

	cusc_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_wr_en(cfg_wr_en),
		.cfg_supervisor(cfg_supervisor), .cfg_wdata(cfg_wdata),
		.cache_config_reg(cache_config_reg), .core_req(core_req),
		.core_ifetch(core_ifetch), .core_we(core_we), .core_addr(core_addr),
		.core_wdata(core_wdata), .core_rdata_r(core_rdata_r),
		.core_ready_r(core_ready_r), .core_miss_r(core_miss_r),
		.ext_req_r(ext_req_r), .ext_we_r(ext_we_r), .ext_burst_r(ext_burst_r),
		.ext_addr_r(ext_addr_r), .ext_wdata_r(ext_wdata_r),
		.ext_ack(ext_ack), .ext_rdata(ext_rdata));
	cusc_ext_mem m (.sys_clk(sys_clk), .rst_n(rst_n), .ext_req_r(ext_req_r),
		.ext_we_r(ext_we_r), .ext_burst_r(ext_burst_r),
		.ext_addr_r(ext_addr_r), .ext_wdata_r(ext_wdata_r),
		.ext_ack(ext_ack), .ext_rdata(ext_rdata), .lat(lat));

	// 40 MHz core clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Hang guard, well above the few thousand cycles the traffic needs
	always @(posedge sys_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 40000) begin
			num_errors++;
			summarize();
		end
	end

	// Line index as the organisation places it
	function automatic logic [8:0] idx(input logic [31:0] a, input logic f);
		return (mode == 2'h2) ? {~f, a[11:4]} : a[12:4];
	endfunction : idx

	// Whether this access kind is cached right now
	function automatic logic cch(input logic f);
		return en && (mode == 2'h0 ? f : mode == 2'h1 ? !f : mode == 2'h2);
	endfunction : cch

	task automatic summarize();
		$display("num_errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize

	task automatic idle();
		core_req = 1'b0;
		@(posedge sys_clk);
		#2;
	endtask : idle

	// Config write; an unprivileged one must leave the register alone
	task automatic cfg(input logic sup, input logic [3:0] d);
		logic [3:0] e;
		e = sup ? {d[3:1], 1'b0} : {en, mode, 1'b0};
		cfg_wr_en = 1'b1;
		cfg_supervisor = sup;
		cfg_wdata = d;
		@(posedge sys_clk);
		#2;
		cfg_wr_en = 1'b0;
		@(posedge sys_clk);
		#2;
		`CHK("config", e, cache_config_reg)
		{en, mode} = e[3:1];
		if (sup && d[0]) begin
			foreach (v[i]) v[i] = 1'b0;
		end
	endtask : cfg

	// One core access; a read hit leaves the strobe up for a back-to-back request
	task automatic acc(input logic f, input logic w, input logic [31:0] a,
		input logic [31:0] wd);
		logic [8:0]  i;
		logic        hit;
		logic        ms;
		logic [31:0] ba;
		int          c;
		int          nw;
		i = idx(a, f);
		hit = cch(f) && v[i] && tg[i] === a[31:12];
		nw = m.n_wr;
		ms = 1'b0;
		ba = 32'h0;
		c = 0;
		core_req = 1'b1;
		core_ifetch = f;
		core_we = w;
		core_addr = a;
		core_wdata = wd;
		do begin
			@(posedge sys_clk);
			#2;
			if (c == 0 && !core_ready_r) begin
				core_req = 1'b0;
			end
			c++;
			ms |= core_miss_r;
			if (ext_req_r && ext_burst_r) begin
				ba = ext_addr_r;
			end
		end while (core_ready_r !== 1'b1 && c < 64);
		`CHK("ready", 1'b1, core_ready_r)
		if (w) begin
			`CHK("ext writes", nw + 1, m.n_wr)
			`CHK("ext word", wd, m.mem[a])
			if (hit) begin
				cd[{i, a[3:2]}] = wd;
			end
		end else begin
			`CHK("miss", !hit && cch(f), ms)
			if (!hit && cch(f)) begin
				`CHK("line base", {a[31:4], 4'h0}, ba)
				v[i] = 1'b1;
				tg[i] = a[31:12];
				for (int k = 0; k < 4; k++) begin
					cd[{i, 2'(k)}] = m.rd({a[31:4], 4'h0} + 32'(4 * k));
				end
			end
			`CHK("rdata", hit ? cd[{i, a[3:2]}] : m.rd(a), core_rdata_r)
			if (hit) begin
				`CHK("hit cycles", 1, c)
			end
		end
	endtask : acc

	// Reset, then random traffic over a small address pool in each mode
	initial begin
		logic [31:0] a;
		logic        f;
		rst_n = 1'b0;
		{cfg_wr_en, cfg_supervisor, cfg_wdata, core_req} = 7'h0;
		{core_ifetch, core_we, core_addr, core_wdata} = 66'h0;
		lat = 2'h0;
		en = 1'b0;
		mode = 2'h0;
		foreach (v[i]) v[i] = 1'b0;
		void'($urandom(55));
		repeat (2) @(posedge sys_clk);
		#2;
		rst_n = 1'b1;
		`CHK("reset config", 4'h0, cache_config_reg)
		`CHK("reset ext", 1'b0, ext_req_r)
		acc(1'b0, 1'b0, 32'h0000_0100, 32'h0);
		cfg(1'b0, 4'hd);
		for (int md = 0; md < 4; md++) begin
			cfg(1'b1, {1'b1, 2'(md), 1'b1});
			repeat (150) begin
				a = $urandom & 32'h0000_383c;
				f = 1'($urandom);
				lat = 2'($urandom);
				acc(f, !f && ($urandom % 3 == 0), a, $urandom);
			end
			idle();
		end
		summarize();
	end
endmodule : tb
`default_nettype wire
